// [core/bisx_alu.sv]
module bisx_alu
   import bisx_pkg::*;
(
   // operation select
   input wire bisx_op_t op_i,
   // operands
   input wire logic [7:0] acc_i,
   input wire logic [7:0] reg_i,
   input wire logic [7:0] imm_i,
   // result
   output logic [7:0] result_o,
   output logic zero_o
);

   // ----------------------------------------
   // operand selection and arithmetic
   // ----------------------------------------
   wire logic [7:0] inc_res = reg_i + 8'h01; // wraps 0xff to 0x00
   wire logic [7:0] ori_res = acc_i | imm_i;
   wire logic [7:0] orr_res = acc_i | reg_i;

   // result mux per operation
   assign result_o = (op_i == OP_INCREMENT_SKIP_ZERO) ? inc_res :
                     (op_i == OP_OR_IMMEDIATE) ? ori_res :
                     (op_i == OP_OR_REGISTER) ? orr_res : 8'h00;

   // zero detect of the selected result
   assign zero_o = (result_o == 8'h00);

endmodule

// [core/bisx_consts.svh]
`ifndef BISX_CONSTS_SVH
`define BISX_CONSTS_SVH

// ----------------------------------------
// reset values
// ----------------------------------------
`define BISX_PC_RST 10'h000
`define BISX_ACC_RST 8'h00
`define BISX_ZERO_RST 1'b0

// ----------------------------------------
// fixed addresses and field positions
// ----------------------------------------
`define BISX_INT_VECTOR 10'h001
`define BISX_TBH_MSB 1
`define BISX_TBH_LSB 0

// ----------------------------------------
// instruction cycle counts
// ----------------------------------------
`define BISX_BRANCH_CYCLES 2
`define BISX_SKIP_CYCLES 2
`define BISX_INT_CYCLES 3

`endif

// [core/bisx_exec.sv]
`include "bisx_consts.svh"

module bisx_exec
   import bisx_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // decoded instruction from fetch
   input wire logic instr_valid_i,
   output logic instr_ready_o,
   input wire bisx_op_t op_i,
   input wire logic [7:0] imm_i,
   input wire logic [5:0] raddr_i,
   input wire logic dest_i,
   input wire logic [3:0] fsel_i,
   // source operands
   input wire logic [7:0] table_pointer_high_i,
   input wire logic [7:0] reg_rdata_i,
   // data register write port
   output logic reg_we_o,
   output logic [5:0] reg_waddr_o,
   output logic [7:0] reg_wdata_o,
   // fpage register write port
   output logic fpage_we_o,
   output logic [3:0] fpage_sel_o,
   output logic [7:0] fpage_wdata_o,
   // return stack push
   output logic stack_push_o,
   output logic [9:0] stack_data_o,
   // core state
   output logic [9:0] pc_o,
   output logic [7:0] working_register_o,
   output logic zero_o,
   output logic fetch_discard_o
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   bisx_state_t state_q, state_d;
   logic [9:0] pc_q, pc_d;
   logic [7:0] acc_q, acc_d;
   logic zero_q, zero_d;
   logic reg_we_q, fpage_we_q, stack_push_q;
   logic [5:0] reg_waddr_q;
   logic [7:0] reg_wdata_q;
   logic [3:0] fpage_sel_q;
   logic [7:0] fpage_wdata_q;
   logic [9:0] stack_data_q;
   logic [7:0] alu_res;
   logic alu_zero;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic accept = instr_valid_i && instr_ready_o;
   wire logic is_br = accept && (op_i == OP_COMPUTED_BRANCH);
   wire logic is_inc = accept && (op_i == OP_INCREMENT_SKIP_ZERO);
   wire logic is_int = accept && (op_i == OP_SOFT_INT);
   wire logic is_ori = accept && (op_i == OP_OR_IMMEDIATE);
   wire logic is_orr = accept && (op_i == OP_OR_REGISTER);
   wire logic is_mov = accept && (op_i == OP_MOVE_TO_FPAGE);
   wire logic two_way = is_inc || is_orr;
   wire logic wr_reg = two_way && dest_i;
   wire logic wr_acc = is_ori || (two_way && !dest_i);
   wire logic do_skip = is_inc && alu_zero;
   wire logic [9:0] pc_inc = pc_q + 10'h001;
   wire logic [9:0] br_target = {table_pointer_high_i[`BISX_TBH_MSB:`BISX_TBH_LSB], acc_q};

   // shared arithmetic for increment and both or forms
   bisx_alu bisx_alu_inst (
      .op_i(op_i),
      .acc_i(acc_q),
      .reg_i(reg_rdata_i),
      .imm_i(imm_i),
      .result_o(alu_res),
      .zero_o(alu_zero)
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   // sequencer: extra cycles for branch, skip and interrupt
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_EXEC: begin
            if (is_br) begin
               state_d = ST_BRANCH;
            end else if (do_skip) begin
               state_d = ST_SKIP;
            end else if (is_int) begin
               state_d = ST_INT_A;
            end
         end
         ST_BRANCH: state_d = ST_EXEC;
         ST_SKIP: state_d = ST_EXEC;
         ST_INT_A: state_d = ST_INT_B;
         ST_INT_B: state_d = ST_EXEC;
         default: state_d = ST_EXEC;
      endcase
   end

   // program counter selection
   assign pc_d = is_br ? br_target :
                 is_int ? `BISX_INT_VECTOR :
                 accept ? pc_inc :
                 (state_q == ST_SKIP) ? pc_inc : pc_q; // step over discarded word

   // working register and zero flag; increment leaves zero alone
   assign acc_d = wr_acc ? alu_res : acc_q;
   assign zero_d = (is_ori || is_orr) ? alu_zero : zero_q;

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // core state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_q <= ST_EXEC;
         pc_q <= `BISX_PC_RST;
         acc_q <= `BISX_ACC_RST;
         zero_q <= `BISX_ZERO_RST;
      end else begin
         state_q <= state_d;
         pc_q <= pc_d;
         acc_q <= acc_d;
         zero_q <= zero_d;
      end
   end

   // write strobes, one cycle each
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_we_q <= 1'b0;
         fpage_we_q <= 1'b0;
         stack_push_q <= 1'b0;
      end else begin
         reg_we_q <= wr_reg;
         fpage_we_q <= is_mov;
         stack_push_q <= is_int;
      end
   end

   // write data, held until the next write of its kind
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_waddr_q <= 6'h00;
         reg_wdata_q <= 8'h00;
         fpage_sel_q <= 4'h0;
         fpage_wdata_q <= 8'h00;
         stack_data_q <= 10'h000;
      end else begin
         if (wr_reg) begin
            reg_waddr_q <= raddr_i;
            reg_wdata_q <= alu_res;
         end
         if (is_mov) begin
            fpage_sel_q <= fsel_i;
            fpage_wdata_q <= acc_q;
         end
         if (is_int) begin
            stack_data_q <= pc_inc;
         end
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign instr_ready_o = (state_q == ST_EXEC);
   assign fetch_discard_o = (state_q == ST_SKIP);
   assign reg_we_o = reg_we_q;
   assign reg_waddr_o = reg_waddr_q;
   assign reg_wdata_o = reg_wdata_q;
   assign fpage_we_o = fpage_we_q;
   assign fpage_sel_o = fpage_sel_q;
   assign fpage_wdata_o = fpage_wdata_q;
   assign stack_push_o = stack_push_q;
   assign stack_data_o = stack_data_q;
   assign pc_o = pc_q;
   assign working_register_o = acc_q;
   assign zero_o = zero_q;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   chk_branch_target: assert property (is_br |=>
      pc_o == {$past(table_pointer_high_i[1:0]), $past(acc_q)})
      else $error("branch target wrong");
   chk_branch_length: assert property (is_br |=> !instr_ready_o ##1 instr_ready_o)
      else $error("branch length wrong");
   chk_inc_dest: assert property ((is_inc && !dest_i) |=>
      (working_register_o == $past(reg_rdata_i) + 8'h01) && !reg_we_o)
      else $error("increment to accumulator wrong");
   chk_skip_seq: assert property ((is_inc && reg_rdata_i == 8'hff) |=>
      fetch_discard_o && !instr_ready_o ##1 instr_ready_o && !fetch_discard_o)
      else $error("skip sequence wrong");
   chk_int_push: assert property (is_int |=>
      stack_push_o && stack_data_o == $past(pc_o) + 10'h001 && pc_o == 10'h001)
      else $error("interrupt push wrong");
   chk_int_length: assert property (is_int |=> !instr_ready_o [*2] ##1 instr_ready_o)
      else $error("interrupt length wrong");
   chk_or_imm: assert property (is_ori |=>
      working_register_o == ($past(acc_q) | $past(imm_i)))
      else $error("or immediate wrong");
   chk_or_reg: assert property ((is_orr && dest_i) |=> reg_we_o &&
      reg_wdata_o == ($past(acc_q) | $past(reg_rdata_i)) && $stable(working_register_o))
      else $error("or register wrong");
   chk_fpage_move: assert property (is_mov |=> fpage_we_o &&
      fpage_wdata_o == $past(acc_q) && fpage_sel_o == $past(fsel_i) && $stable(working_register_o))
      else $error("fpage move wrong");
   chk_zero_flag: assert property ((is_ori || is_orr) |=> zero_o == ((($past(acc_q) |
      ($past(is_ori) ? $past(imm_i) : $past(reg_rdata_i))) == 8'h00)))
      else $error("zero flag wrong");

   cov_branch: cover property (is_br ##2 accept);
   cov_skip: cover property (is_inc && alu_zero ##2 accept);
   cov_int: cover property (is_int ##3 accept);
   cov_or_zero: cover property (is_orr && alu_zero);

endmodule

// [core/bisx_pkg.sv]
package bisx_pkg;

   // ----------------------------------------
   // decoded operations seen by the executor
   // ----------------------------------------
   typedef enum logic [2:0] {
      OP_NOP = 3'h0,
      OP_COMPUTED_BRANCH = 3'h1,
      OP_INCREMENT_SKIP_ZERO = 3'h2,
      OP_SOFT_INT = 3'h3,
      OP_OR_IMMEDIATE = 3'h4,
      OP_OR_REGISTER = 3'h5,
      OP_MOVE_TO_FPAGE = 3'h6
   } bisx_op_t;

   // ----------------------------------------
   // sequencer states, one-hot
   // ----------------------------------------
   typedef enum logic [4:0] {
      ST_EXEC = 5'b00001,
      ST_BRANCH = 5'b00010,
      ST_SKIP = 5'b00100,
      ST_INT_A = 5'b01000,
      ST_INT_B = 5'b10000
   } bisx_state_t;

endpackage

// [tb/bisx_regfile_model.sv]
module bisx_regfile_model
   import bisx_pkg::*;
(
   // clock
   input wire logic clk_i,
   // read port
   input wire logic [5:0] raddr_i,
   output logic [7:0] rdata_o,
   // write port
   input wire logic we_i,
   input wire logic [5:0] waddr_i,
   input wire logic [7:0] wdata_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [64];
   // read is combinational, but the strobe comes a cycle late, so a write shows from the second back-to-back instruction after it
   assign rdata_o = mem[raddr_i];
   // write lands on the strobe edge; bench preloads from outside
   always @(posedge clk_i) begin
      if (we_i === 1'b1) begin
         mem[waddr_i] <= wdata_i;
      end
   end
endmodule

// [tb/branch_incskip_or_sfr_exec_tb_top.sv]
module branch_incskip_or_sfr_exec_tb_top
   import bisx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic instr_valid_i = 1'b0;
   bisx_op_t op_i = OP_NOP;
   logic [7:0] imm_i = 8'h00;
   logic [5:0] raddr_i = 6'h00;
   logic dest_i = 1'b0;
   logic [3:0] fsel_i = 4'hf;
   logic [7:0] tbh = 8'hfe;
   logic [7:0] rdata, wdata, fdata, acc;
   logic rdy, we, fwe, push, zero_o, disc;
   logic [5:0] waddr;
   logic [3:0] fsel_o;
   logic [9:0] sdata, pc_o;
   int miscompares = 0;
   int checked = 0;
   bisx_exec bisx_exec_inst (.clk_i, .sys_rst_i, .instr_valid_i, .instr_ready_o(rdy), .op_i, .imm_i,
      .raddr_i, .dest_i, .fsel_i, .table_pointer_high_i(tbh), .reg_rdata_i(rdata), .reg_we_o(we),
      .reg_waddr_o(waddr), .reg_wdata_o(wdata), .fpage_we_o(fwe), .fpage_sel_o(fsel_o),
      .fpage_wdata_o(fdata), .stack_push_o(push), .stack_data_o(sdata), .pc_o,
      .working_register_o(acc), .zero_o, .fetch_discard_o(disc));
   bisx_regfile_model bisx_regfile_model_inst (.clk_i, .raddr_i, .rdata_o(rdata), .we_i(we),
      .waddr_i(waddr), .wdata_i(wdata));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   // offer an instruction at a falling edge, return at the one after it is taken
   task automatic issue(input bisx_op_t op, input logic [7:0] imm, input logic [5:0] ra, input logic d);
      int n = 0;
      op_i = op;
      imm_i = imm;
      raddr_i = ra;
      dest_i = d;
      instr_valid_i = 1'b1;
      while (rdy !== 1'b1 && n < 20) begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
   endtask
   task automatic idle();
      instr_valid_i = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_or_imm();
      issue(OP_OR_IMMEDIATE, 8'h00, 6'h00, 1'b0);
      chk("zero", 10'h001, 10'(zero_o));
      issue(OP_OR_IMMEDIATE, 8'h50, 6'h00, 1'b0);
      issue(OP_OR_IMMEDIATE, 8'haa, 6'h00, 1'b0);
      chk("acc", 10'h0fa, 10'(acc));
      chk("zero", 10'h000, 10'(zero_o));
      chk("pc", 10'h003, pc_o);
      idle();
   endtask
   task automatic t_fpage();
      issue(OP_MOVE_TO_FPAGE, 8'h00, 6'h00, 1'b0);
      chk("fwe", 10'h001, 10'(fwe));
      chk("fsel", 10'h00f, 10'(fsel_o));
      chk("fdata", 10'h0fa, 10'(fdata));
      chk("acc", 10'h0fa, 10'(acc));
      chk("pc", 10'h004, pc_o);
      idle();
   endtask
   task automatic t_or_reg();
      issue(OP_OR_REGISTER, 8'h00, 6'h3f, 1'b1);
      chk("we", 10'h001, 10'(we));
      chk("waddr", 10'h03f, 10'(waddr));
      chk("wdata", 10'h0ff, 10'(wdata));
      chk("acc", 10'h0fa, 10'(acc));
      issue(OP_OR_REGISTER, 8'h00, 6'h3e, 1'b0);
      chk("we", 10'h000, 10'(we));
      chk("acc", 10'h0fb, 10'(acc));
      chk("zero", 10'h000, 10'(zero_o));
      idle();
   endtask
   task automatic t_incr();
      issue(OP_INCREMENT_SKIP_ZERO, 8'h00, 6'h10, 1'b0);
      chk("acc", 10'h011, 10'(acc));
      chk("disc", 10'h000, 10'(disc));
      chk("rdy", 10'h001, 10'(rdy));
      chk("pc", 10'h007, pc_o);
      issue(OP_INCREMENT_SKIP_ZERO, 8'h00, 6'h11, 1'b1);
      chk("we", 10'h001, 10'(we));
      chk("waddr", 10'h011, 10'(waddr));
      chk("wdata", 10'h000, 10'(wdata));
      chk("disc", 10'h001, 10'(disc));
      chk("rdy", 10'h000, 10'(rdy));
      idle();
      chk("rdy", 10'h001, 10'(rdy));
      chk("pc", 10'h009, pc_o);
   endtask
   task automatic t_branch();
      issue(OP_COMPUTED_BRANCH, 8'h00, 6'h00, 1'b0);
      chk("pc", 10'h211, pc_o);
      chk("rdy", 10'h000, 10'(rdy));
      idle();
      chk("rdy", 10'h001, 10'(rdy));
      chk("pc", 10'h211, pc_o);
      // other table pointer bits: only bits 1:0 reach the pc
      tbh = 8'h01;
      issue(OP_COMPUTED_BRANCH, 8'h00, 6'h00, 1'b0);
      chk("pc", 10'h111, pc_o);
      idle();
   endtask
   task automatic t_int();
      issue(OP_SOFT_INT, 8'h00, 6'h00, 1'b0);
      chk("push", 10'h001, 10'(push));
      chk("sdata", 10'h112, sdata);
      chk("pc", 10'h001, pc_o);
      chk("rdy", 10'h000, 10'(rdy));
      idle();
      chk("rdy", 10'h000, 10'(rdy));
      @(negedge clk_i);
      chk("rdy", 10'h001, 10'(rdy));
   endtask
   // increment to zero into the accumulator, then an or with a zero register
   task automatic t_or_zero();
      issue(OP_INCREMENT_SKIP_ZERO, 8'h00, 6'h3f, 1'b0);
      chk("acc", 10'h000, 10'(acc));
      chk("we", 10'h000, 10'(we));
      chk("disc", 10'h001, 10'(disc));
      issue(OP_OR_REGISTER, 8'h00, 6'h11, 1'b0);
      chk("zero", 10'h001, 10'(zero_o));
      chk("acc", 10'h000, 10'(acc));
      chk("pc", 10'h004, pc_o);
      fsel_i = 4'h3;
      issue(OP_MOVE_TO_FPAGE, 8'h00, 6'h00, 1'b0);
      chk("fsel", 10'h003, 10'(fsel_o));
      chk("fdata", 10'h000, 10'(fdata));
      idle();
   endtask
   // ----------------------------------------
   // clock, main sequence, watchdog
   // ----------------------------------------
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      bisx_regfile_model_inst.mem[63] = 8'h05;
      bisx_regfile_model_inst.mem[62] = 8'h01;
      bisx_regfile_model_inst.mem[16] = 8'h10;
      bisx_regfile_model_inst.mem[17] = 8'hff;
      repeat (3) @(negedge clk_i);
      sys_rst_i = 1'b0;
      t_or_imm();
      t_fpage();
      t_or_reg();
      t_incr();
      t_branch();
      t_int();
      t_or_zero();
      end_of_test();
   end
   initial begin
      repeat (500) @(posedge clk_i);
      miscompares++;
      end_of_test();
   end
endmodule
